// File: verilog/core_regs_pkg.sv
// Field layout, codes and reset values of the core control and cache setup registers
package core_regs_pkg;
   // Core control and status register fields
   localparam int CSR_SLEEP_HI = 15;
   localparam int CSR_SLEEP_LO = 10;
   localparam int CSR_CLIP_BIT = 9;
   localparam int CSR_PMODE_HI = 7;
   localparam int CSR_PMODE_LO = 5;
   localparam int CSR_DMODE_HI = 4;
   localparam int CSR_DMODE_LO = 2;
   localparam int CSR_SAVED_BIT = 1;
   localparam int CSR_IRQ_EN_BIT = 0;
   localparam int CSR_ORDER_BIT = 8;
   localparam int CSR_ID_HI = 31;
   localparam int CSR_ID_LO = 16;
   // Cache setup register fields
   localparam int SETUP_PRIO_BIT = 31;
   localparam int SETUP_PFLUSH_BIT = 9;
   localparam int SETUP_DFLUSH_BIT = 8;
   localparam int SETUP_L2_HI = 2;
   localparam int SETUP_L2_LO = 0;
   localparam int SETUP_RSVD_TOP = 30;
   localparam int SETUP_RSVD_BOT = 3;
   localparam logic [20:0] SETUP_RSVD_HI_VAL = 21'h00000;
   localparam logic [4:0] SETUP_RSVD_LO_VAL = 5'h00;
   // Register select on the control-move port
   localparam logic REG_SEL_CSR = 1'b0;
   localparam logic REG_SEL_SETUP = 1'b1;
   // Sleep request codes
   localparam logic [5:0] SLEEP_CODE_NONE = 6'h00;
   localparam logic [5:0] SLEEP_CODE_LIGHT_EN = 6'h09;
   localparam logic [5:0] SLEEP_CODE_LIGHT_ANY = 6'h11;
   localparam logic [5:0] SLEEP_CODE_DEEP_A = 6'h1a;
   localparam logic [5:0] SLEEP_CODE_DEEP_B = 6'h1c;
   localparam logic [5:0] SLEEP_READ_VAL = 6'h00;
   // Cache mode codes
   localparam logic [2:0] CACHE_MODE_ON_A = 3'h0;
   localparam logic [2:0] CACHE_MODE_ON_B = 3'h2;
   localparam logic [2:0] CACHE_MODE_RESET = 3'h0;
   // Level 2 way select codes
   localparam logic [2:0] L2_ALL_SRAM = 3'h0;
   localparam logic [2:0] L2_ONE_WAY = 3'h1;
   localparam logic [2:0] L2_TWO_WAY = 3'h2;
   localparam logic [2:0] L2_THREE_WAY = 3'h3;
   localparam logic [2:0] L2_FOUR_WAY = 3'h7;
   // Reset values
   localparam logic ORDER_LITTLE_RESET = 1'b1;
   localparam logic IRQ_ENABLE_RESET = 1'b0;
   localparam logic PRIO_RESET = 1'b0;

   typedef enum logic [2:0] {
      SLEEP_AWAKE = 3'b000,
      SLEEP_LIGHT_EN = 3'b001,
      SLEEP_LIGHT_ANY = 3'b010,
      SLEEP_DEEP_A = 3'b011,
      SLEEP_DEEP_B = 3'b100
   } sleep_state_type;

   function automatic logic cache_mode_legal(input logic [2:0] code);
      cache_mode_legal = (code == CACHE_MODE_ON_A) || (code == CACHE_MODE_ON_B);
   endfunction

   function automatic logic l2_mode_legal(input logic [2:0] code);
      l2_mode_legal = (code == L2_ALL_SRAM) || (code == L2_ONE_WAY) ||
         (code == L2_TWO_WAY) || (code == L2_THREE_WAY) || (code == L2_FOUR_WAY);
   endfunction
endpackage

// File: verilog/clip_sticky.sv
// Sticky clip flag: set by functional units, cleared by control-move writes of zero to the clip bit
`timescale 1ns/1ps
module clip_sticky import core_regs_pkg::*; (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clip_event,
   input wire logic clip_cond_true,
   input wire logic clear_strobe,
   output logic clip_sticky_flag
);
   typedef struct packed {
      logic flag;
   } clip_state_type;

   clip_state_type st_reg;
   clip_state_type st_next;

   always_comb begin
      st_next = st_reg;
      // The event in the same cycle as a clear wins, so the clear goes first
      if (clear_strobe) begin
         st_next.flag = 1'b0;
      end
      if (clip_event && clip_cond_true) begin
         st_next.flag = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign clip_sticky_flag = st_reg.flag;

   property p_clip_set_next;
      @(posedge clk_sys) disable iff (!rst_n)
      (clip_event && clip_cond_true) |=> clip_sticky_flag;
   endproperty
   a_clip_set_next: assert property (p_clip_set_next) else $error("clip flag not set");

   property p_clip_set_wins;
      @(posedge clk_sys) disable iff (!rst_n)
      (clip_event && clip_cond_true && clear_strobe) |=> clip_sticky_flag;
   endproperty
   a_clip_set_wins: assert property (p_clip_set_wins) else $error("clear beat set");

   property p_clip_false_cond;
      @(posedge clk_sys) disable iff (!rst_n)
      (!clip_sticky_flag && !clear_strobe && !(clip_event && clip_cond_true))
         |=> !clip_sticky_flag;
   endproperty
   a_clip_false_cond: assert property (p_clip_false_cond)
      else $error("flag set w/o cause");

   property p_clip_only_clear;
      @(posedge clk_sys) disable iff (!rst_n)
      (clip_sticky_flag && !clear_strobe) |=> clip_sticky_flag;
   endproperty
   a_clip_only_clear: assert property (p_clip_only_clear) else $error("flag lost");

   c_clip_collide: cover property (@(posedge clk_sys) disable iff (!rst_n)
      clip_event && clip_cond_true && clear_strobe);
endmodule

// File: verilog/sleep_control.sv
// Decodes sleep requests and holds the sleep state until its wake condition
`timescale 1ns/1ps
module sleep_control import core_regs_pkg::*; (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic req_strobe,
   input wire logic [5:0] req_code,
   input wire logic wake_enabled_irq,
   input wire logic wake_any_irq,
   output logic sleep_light,
   output logic sleep_deep
);
   typedef struct packed {
      sleep_state_type state;
      logic light;
      logic deep;
   } sleep_fsm_type;

   sleep_fsm_type st_reg;
   sleep_fsm_type st_next;
   sleep_state_type nxt;

   always_comb begin
      st_next = st_reg;
      nxt = st_reg.state;
      case (st_reg.state)
         SLEEP_AWAKE: begin
            // Reserved codes and the no-sleep code leave the core running
            if (req_strobe) begin
               if (req_code == SLEEP_CODE_LIGHT_EN) begin
                  nxt = SLEEP_LIGHT_EN;
               end else if (req_code == SLEEP_CODE_LIGHT_ANY) begin
                  nxt = SLEEP_LIGHT_ANY;
               end else if (req_code == SLEEP_CODE_DEEP_A) begin
                  nxt = SLEEP_DEEP_A;
               end else if (req_code == SLEEP_CODE_DEEP_B) begin
                  nxt = SLEEP_DEEP_B;
               end
            end
         end
         SLEEP_LIGHT_EN: begin
            if (wake_enabled_irq) begin
               nxt = SLEEP_AWAKE;
            end
         end
         SLEEP_LIGHT_ANY: begin
            if (wake_enabled_irq || wake_any_irq) begin
               nxt = SLEEP_AWAKE;
            end
         end
         // Deep states leave only through device reset
         SLEEP_DEEP_A: nxt = SLEEP_DEEP_A;
         SLEEP_DEEP_B: nxt = SLEEP_DEEP_B;
         default: nxt = SLEEP_AWAKE;
      endcase
      st_next.state = nxt;
      st_next.light = (nxt == SLEEP_LIGHT_EN) || (nxt == SLEEP_LIGHT_ANY);
      st_next.deep = (nxt == SLEEP_DEEP_A) || (nxt == SLEEP_DEEP_B);
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '{state: SLEEP_AWAKE, light: 1'b0, deep: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign sleep_light = st_reg.light;
   assign sleep_deep = st_reg.deep;

   property p_deep_sticks;
      @(posedge clk_sys) disable iff (!rst_n)
      sleep_deep |=> sleep_deep && !sleep_light;
   endproperty
   a_deep_sticks: assert property (p_deep_sticks) else $error("left deep sleep");

   property p_light_enter;
      @(posedge clk_sys) disable iff (!rst_n)
      (!sleep_light && !sleep_deep && req_strobe && req_code == SLEEP_CODE_LIGHT_EN)
         |=> sleep_light;
   endproperty
   a_light_enter: assert property (p_light_enter) else $error("no light sleep");

   c_deep: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(sleep_deep));
endmodule

// File: verilog/cpu_status_cache_config.sv
// Core control/status and cache setup registers on the control-move port
`timescale 1ns/1ps
module cpu_status_cache_config import core_regs_pkg::*; #(
   parameter logic [7:0] KIND_CODE = 8'h5a, // Arbitrary value
   parameter logic [7:0] REV_CODE = 8'h01 // Arbitrary value
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ctl_wr,
   input wire logic ctl_rd,
   input wire logic ctl_sel,
   input wire logic [31:0] ctl_wdata,
   input wire logic endian_strap_little,
   input wire logic clip_event,
   input wire logic clip_cond_true,
   input wire logic irq_taken,
   input wire logic irq_return,
   input wire logic irq_maskable_req,
   input wire logic irq_nmi_req,
   input wire logic l1d_req,
   input wire logic xbar_req,
   output logic [31:0] ctl_rdata,
   output logic ctl_rvalid,
   output logic clip_sticky_flag,
   output logic order_little,
   output logic [2:0] instr_cache_mode,
   output logic [2:0] data_cache_mode,
   output logic saved_irq_enable,
   output logic global_irq_enable,
   output logic irq_deliver,
   output logic xbar_priority,
   output logic prog_cache_flush,
   output logic data_cache_flush,
   output logic [2:0] level2_way_select,
   output logic l1d_grant,
   output logic xbar_grant,
   output logic sleep_light,
   output logic sleep_deep
);
   typedef struct packed {
      logic [31:0] rdata;
      logic rvalid;
      logic order_little;
      logic order_caught;
      logic [2:0] pmode;
      logic [2:0] dmode;
      logic saved_ie;
      logic irq_en;
      logic deliver;
      logic prio;
      logic pflush;
      logic dflush;
      logic [2:0] l2;
      logic l1d_gnt;
      logic xbar_gnt;
   } core_state_type;

   localparam core_state_type CORE_RESET = '{
      rdata: 32'h00000000, rvalid: 1'b0, order_little: ORDER_LITTLE_RESET,
      order_caught: 1'b0, pmode: CACHE_MODE_RESET, dmode: CACHE_MODE_RESET,
      saved_ie: IRQ_ENABLE_RESET, irq_en: IRQ_ENABLE_RESET, deliver: 1'b0,
      prio: PRIO_RESET, pflush: 1'b0, dflush: 1'b0, l2: L2_ALL_SRAM,
      l1d_gnt: 1'b0, xbar_gnt: 1'b0};

   core_state_type st_reg;
   core_state_type st_next;
   logic wr_csr;
   logic wr_setup;
   logic clip_flag;

   assign wr_csr = ctl_wr && (ctl_sel == REG_SEL_CSR);
   assign wr_setup = ctl_wr && (ctl_sel == REG_SEL_SETUP);

   clip_sticky u_clip (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clip_event(clip_event),
      .clip_cond_true(clip_cond_true),
      .clear_strobe(wr_csr && !ctl_wdata[CSR_CLIP_BIT]),
      .clip_sticky_flag(clip_flag)
   );

   sleep_control u_sleep (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .req_strobe(wr_csr),
      .req_code(ctl_wdata[CSR_SLEEP_HI:CSR_SLEEP_LO]),
      .wake_enabled_irq(irq_maskable_req && st_reg.irq_en),
      .wake_any_irq(irq_maskable_req || irq_nmi_req),
      .sleep_light(sleep_light),
      .sleep_deep(sleep_deep)
   );

   always_comb begin
      st_next = st_reg;
      st_next.rvalid = ctl_rd;
      // Flush strobes last one cycle so the caches are never held invalid
      st_next.pflush = 1'b0;
      st_next.dflush = 1'b0;
      // Strap is taken once, after reset has been released
      if (!st_reg.order_caught) begin
         st_next.order_little = endian_strap_little;
         st_next.order_caught = 1'b1;
      end
      if (ctl_rd) begin
         if (ctl_sel == REG_SEL_CSR) begin
            st_next.rdata = {KIND_CODE, REV_CODE, SLEEP_READ_VAL, clip_flag,
               st_reg.order_little, st_reg.pmode, st_reg.dmode, st_reg.saved_ie, st_reg.irq_en};
         end else begin
            // Flush bits are write-only and read back as zero
            st_next.rdata = {st_reg.prio, SETUP_RSVD_HI_VAL, 1'b0, 1'b0,
               SETUP_RSVD_LO_VAL, st_reg.l2};
         end
      end
      if (wr_csr) begin
         // Reserved cache mode codes are dropped rather than stored
         if (cache_mode_legal(ctl_wdata[CSR_PMODE_HI:CSR_PMODE_LO])) begin
            st_next.pmode = ctl_wdata[CSR_PMODE_HI:CSR_PMODE_LO];
         end
         if (cache_mode_legal(ctl_wdata[CSR_DMODE_HI:CSR_DMODE_LO])) begin
            st_next.dmode = ctl_wdata[CSR_DMODE_HI:CSR_DMODE_LO];
         end
         st_next.saved_ie = ctl_wdata[CSR_SAVED_BIT];
         st_next.irq_en = ctl_wdata[CSR_IRQ_EN_BIT];
      end
      if (irq_return) begin
         st_next.irq_en = st_reg.saved_ie;
      end
      // Taking an interrupt outranks a software write in the same cycle
      if (irq_taken) begin
         st_next.saved_ie = st_reg.irq_en;
         st_next.irq_en = 1'b0;
      end
      // Non-maskable requests ignore the global enable
      st_next.deliver = irq_nmi_req || (irq_maskable_req && st_reg.irq_en);
      if (wr_setup) begin
         st_next.prio = ctl_wdata[SETUP_PRIO_BIT];
         st_next.pflush = ctl_wdata[SETUP_PFLUSH_BIT];
         st_next.dflush = ctl_wdata[SETUP_DFLUSH_BIT];
         if (l2_mode_legal(ctl_wdata[SETUP_L2_HI:SETUP_L2_LO])) begin
            st_next.l2 = ctl_wdata[SETUP_L2_HI:SETUP_L2_LO];
         end
      end
      // One grant per cycle; the priority bit breaks a tie
      st_next.l1d_gnt = l1d_req && (!xbar_req || !st_reg.prio);
      st_next.xbar_gnt = xbar_req && (!l1d_req || st_reg.prio);
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= CORE_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign ctl_rdata = st_reg.rdata;
   assign ctl_rvalid = st_reg.rvalid;
   assign clip_sticky_flag = clip_flag;
   assign order_little = st_reg.order_little;
   assign instr_cache_mode = st_reg.pmode;
   assign data_cache_mode = st_reg.dmode;
   assign saved_irq_enable = st_reg.saved_ie;
   assign global_irq_enable = st_reg.irq_en;
   assign irq_deliver = st_reg.deliver;
   assign xbar_priority = st_reg.prio;
   assign prog_cache_flush = st_reg.pflush;
   assign data_cache_flush = st_reg.dflush;
   assign level2_way_select = st_reg.l2;
   assign l1d_grant = st_reg.l1d_gnt;
   assign xbar_grant = st_reg.xbar_gnt;

   property p_id_read;
      @(posedge clk_sys) disable iff (!rst_n)
      (ctl_rd && ctl_sel == REG_SEL_CSR)
         |=> ctl_rvalid && ctl_rdata[CSR_ID_HI:CSR_ID_LO] == {KIND_CODE, REV_CODE};
   endproperty
   a_id_read: assert property (p_id_read) else $error("bad identity code");

   property p_sleep_reads_zero;
      @(posedge clk_sys) disable iff (!rst_n)
      (ctl_rd && ctl_sel == REG_SEL_CSR)
         |=> ctl_rdata[CSR_SLEEP_HI:CSR_SLEEP_LO] == SLEEP_READ_VAL;
   endproperty
   a_sleep_reads_zero: assert property (p_sleep_reads_zero)
      else $error("sleep field not 0");

   property p_order_read;
      @(posedge clk_sys) disable iff (!rst_n)
      (ctl_rd && ctl_sel == REG_SEL_CSR) |=> ctl_rdata[CSR_ORDER_BIT] == $past(order_little);
   endproperty
   a_order_read: assert property (p_order_read) else $error("byte-order bit wrong");

   property p_clip_read;
      @(posedge clk_sys) disable iff (!rst_n)
      (ctl_rd && ctl_sel == REG_SEL_CSR) |=> ctl_rdata[CSR_CLIP_BIT] == $past(clip_sticky_flag);
   endproperty
   a_clip_read: assert property (p_clip_read) else $error("clip bit read wrong");

   property p_pmode_reserved;
      @(posedge clk_sys) disable iff (!rst_n)
      (wr_csr && !cache_mode_legal(ctl_wdata[CSR_PMODE_HI:CSR_PMODE_LO]))
         |=> $stable(instr_cache_mode);
   endproperty
   a_pmode_reserved: assert property (p_pmode_reserved)
      else $error("reserved pmode taken");

   property p_dmode_legal;
      @(posedge clk_sys) disable iff (!rst_n)
      cache_mode_legal(data_cache_mode);
   endproperty
   a_dmode_legal: assert property (p_dmode_legal) else $error("illegal dmode held");

   property p_irq_save;
      @(posedge clk_sys) disable iff (!rst_n)
      irq_taken |=> saved_irq_enable == $past(global_irq_enable) && !global_irq_enable;
   endproperty
   a_irq_save: assert property (p_irq_save) else $error("enable not saved");

   property p_irq_return;
      @(posedge clk_sys) disable iff (!rst_n)
      (irq_return && !irq_taken) |=> global_irq_enable == $past(saved_irq_enable);
   endproperty
   a_irq_return: assert property (p_irq_return) else $error("enable not restored");

   property p_irq_en_gate;
      @(posedge clk_sys) disable iff (!rst_n)
      (irq_maskable_req && !irq_nmi_req && !global_irq_enable) |=> !irq_deliver;
   endproperty
   a_irq_en_gate: assert property (p_irq_en_gate) else $error("masked irq delivered");

   property p_nmi_deliver;
      @(posedge clk_sys) disable iff (!rst_n)
      irq_nmi_req |=> irq_deliver;
   endproperty
   a_nmi_deliver: assert property (p_nmi_deliver) else $error("nmi not delivered");

   property p_arb;
      @(posedge clk_sys) disable iff (!rst_n)
      (l1d_req && xbar_req) |=> (xbar_grant == $past(xbar_priority)) && (l1d_grant != xbar_grant);
   endproperty
   a_arb: assert property (p_arb) else $error("arbitration wrong");

   property p_prio_write;
      @(posedge clk_sys) disable iff (!rst_n)
      wr_setup |=> xbar_priority == $past(ctl_wdata[SETUP_PRIO_BIT]);
   endproperty
   a_prio_write: assert property (p_prio_write) else $error("priority not written");

   property p_setup_rsvd;
      @(posedge clk_sys) disable iff (!rst_n)
      (ctl_rd && ctl_sel == REG_SEL_SETUP)
         |=> ctl_rdata[SETUP_RSVD_TOP:SETUP_RSVD_BOT] == 28'h0000000;
   endproperty
   a_setup_rsvd: assert property (p_setup_rsvd) else $error("reserved bits nonzero");

   property p_pflush;
      @(posedge clk_sys) disable iff (!rst_n)
      (wr_setup && ctl_wdata[SETUP_PFLUSH_BIT])
         |=> prog_cache_flush ##1 (!prog_cache_flush || $past(wr_setup));
   endproperty
   a_pflush: assert property (p_pflush) else $error("program flush missing");

   property p_pflush_pulse;
      @(posedge clk_sys) disable iff (!rst_n)
      prog_cache_flush |-> $past(wr_setup && ctl_wdata[SETUP_PFLUSH_BIT]);
   endproperty
   a_pflush_pulse: assert property (p_pflush_pulse) else $error("stray program flush");

   property p_dflush_fire;
      @(posedge clk_sys) disable iff (!rst_n)
      (wr_setup && ctl_wdata[SETUP_DFLUSH_BIT]) |=> data_cache_flush;
   endproperty
   a_dflush_fire: assert property (p_dflush_fire) else $error("data flush missing");

   property p_dflush_pulse;
      @(posedge clk_sys) disable iff (!rst_n)
      data_cache_flush |-> $past(wr_setup && ctl_wdata[SETUP_DFLUSH_BIT]);
   endproperty
   a_dflush_pulse: assert property (p_dflush_pulse)
      else $error("stray data flush");

   property p_l2_legal;
      @(posedge clk_sys) disable iff (!rst_n)
      (wr_setup && !l2_mode_legal(ctl_wdata[SETUP_L2_HI:SETUP_L2_LO]))
         |=> $stable(level2_way_select);
   endproperty
   a_l2_legal: assert property (p_l2_legal) else $error("reserved way code taken");

   property p_l2_write;
      @(posedge clk_sys) disable iff (!rst_n)
      (wr_setup && l2_mode_legal(ctl_wdata[SETUP_L2_HI:SETUP_L2_LO]))
         |=> level2_way_select == $past(ctl_wdata[SETUP_L2_HI:SETUP_L2_LO]);
   endproperty
   a_l2_write: assert property (p_l2_write) else $error("way code not taken");

   c_irq_nest: cover property (@(posedge clk_sys) disable iff (!rst_n)
      irq_taken && global_irq_enable);
   c_flush: cover property (@(posedge clk_sys) disable iff (!rst_n)
      prog_cache_flush && data_cache_flush);
   c_xbar_wins: cover property (@(posedge clk_sys) disable iff (!rst_n) xbar_grant && l1d_req);
endmodule

// File: testbench/test_cpu_status_cache_config.sv
// Self-checking bench for the core control/status and cache setup registers
`timescale 1ns/1ps
module test_cpu_status_cache_config;
   localparam logic [7:0] KIND = 8'h3c; // Arbitrary value
   localparam logic [7:0] REV = 8'h07; // Arbitrary value
   logic clk_sys, rst_n, ctl_wr, ctl_rd, ctl_sel, endian_strap_little;
   logic clip_event, clip_cond_true, irq_taken, irq_return, irq_maskable_req, irq_nmi_req;
   logic l1d_req, xbar_req, ctl_rvalid, clip_sticky_flag, order_little;
   logic saved_irq_enable, global_irq_enable, irq_deliver, xbar_priority;
   logic prog_cache_flush, data_cache_flush, l1d_grant, xbar_grant, sleep_light, sleep_deep;
   logic [31:0] ctl_wdata, ctl_rdata, rd_val;
   logic [2:0] instr_cache_mode, data_cache_mode, level2_way_select;
   int error_cnt = 0;
   int comparisons = 0;

   cpu_status_cache_config #(.KIND_CODE(KIND), .REV_CODE(REV)) DUT (
      .clk_sys(clk_sys), .rst_n(rst_n), .ctl_wr(ctl_wr), .ctl_rd(ctl_rd),
      .ctl_sel(ctl_sel), .ctl_wdata(ctl_wdata), .endian_strap_little(endian_strap_little),
      .clip_event(clip_event), .clip_cond_true(clip_cond_true), .irq_taken(irq_taken),
      .irq_return(irq_return), .irq_maskable_req(irq_maskable_req),
      .irq_nmi_req(irq_nmi_req), .l1d_req(l1d_req), .xbar_req(xbar_req),
      .ctl_rdata(ctl_rdata), .ctl_rvalid(ctl_rvalid), .clip_sticky_flag(clip_sticky_flag),
      .order_little(order_little), .instr_cache_mode(instr_cache_mode),
      .data_cache_mode(data_cache_mode), .saved_irq_enable(saved_irq_enable),
      .global_irq_enable(global_irq_enable), .irq_deliver(irq_deliver),
      .xbar_priority(xbar_priority), .prog_cache_flush(prog_cache_flush),
      .data_cache_flush(data_cache_flush), .level2_way_select(level2_way_select),
      .l1d_grant(l1d_grant), .xbar_grant(xbar_grant), .sleep_light(sleep_light),
      .sleep_deep(sleep_deep)
   );

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic report_and_stop();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   // Outputs are looked at on the falling edge, half a cycle after they launch
   task automatic wr(input logic sel, input logic [31:0] d);
      @(negedge clk_sys);
      ctl_wr = 1'b1;
      ctl_sel = sel;
      ctl_wdata = d;
      @(negedge clk_sys);
      ctl_wr = 1'b0;
   endtask

   task automatic rd(input logic sel, output logic [31:0] d);
      @(negedge clk_sys);
      ctl_rd = 1'b1;
      ctl_sel = sel;
      @(negedge clk_sys);
      ctl_rd = 1'b0;
      chk("read valid", 32'h1, {31'h0, ctl_rvalid});
      d = ctl_rdata;
   endtask

   function automatic logic [31:0] csr_exp(input logic clip, input logic ord,
         input logic [2:0] pm, input logic [2:0] dm, input logic sv, input logic ge);
      csr_exp = {KIND, REV, 6'h00, clip, ord, pm, dm, sv, ge};
   endfunction

   task automatic do_reset();
      rst_n = 1'b0;
      cyc(4);
      rst_n = 1'b1;
   endtask

   task automatic t_reset();
      rd(1'b0, rd_val);
      chk("csr after reset", csr_exp(0, 1, 3'h0, 3'h0, 0, 0), rd_val);
      rd(1'b1, rd_val);
      chk("setup after reset", 32'h0000_0000, rd_val);
   endtask

   task automatic t_csr_fields();
      // Read-only identity, byte order and a reserved sleep code in the same write
      wr(1'b0, 32'hffff_b449);
      rd(1'b0, rd_val);
      chk("csr fields", csr_exp(0, 1, 3'h2, 3'h2, 0, 1), rd_val);
      chk("reserved sleep", 32'h0, {30'h0, sleep_light, sleep_deep});
      wr(1'b0, 32'h0000_00bd);
      chk("program mode kept", 32'h2, {29'h0, instr_cache_mode});
      chk("data mode kept", 32'h2, {29'h0, data_cache_mode});
      wr(1'b0, 32'h0000_0001);
      chk("program mode", 32'h0, {29'h0, instr_cache_mode});
      chk("data mode", 32'h0, {29'h0, data_cache_mode});
   endtask

   task automatic t_clip();
      @(negedge clk_sys);
      clip_event = 1'b1;
      clip_cond_true = 1'b0;
      @(negedge clk_sys);
      clip_cond_true = 1'b1;
      chk("clip false cond", 32'h0, {31'h0, clip_sticky_flag});
      @(negedge clk_sys);
      clip_event = 1'b0;
      chk("clip set", 32'h1, {31'h0, clip_sticky_flag});
      wr(1'b0, 32'h0000_0201);
      chk("clip write one", 32'h1, {31'h0, clip_sticky_flag});
      @(negedge clk_sys);
      ctl_wr = 1'b1;
      ctl_sel = 1'b0;
      ctl_wdata = 32'h0000_0001;
      clip_event = 1'b1;
      @(negedge clk_sys);
      ctl_wr = 1'b0;
      clip_event = 1'b0;
      chk("clip set beats clear", 32'h1, {31'h0, clip_sticky_flag});
      wr(1'b0, 32'h0000_0001);
      chk("clip cleared", 32'h0, {31'h0, clip_sticky_flag});
   endtask

   task automatic t_irq();
      @(negedge clk_sys);
      irq_taken = 1'b1;
      @(negedge clk_sys);
      irq_taken = 1'b0;
      chk("saved enable", 32'h2, {30'h0, saved_irq_enable, global_irq_enable});
      irq_maskable_req = 1'b1;
      cyc(2);
      chk("maskable blocked", 32'h0, {31'h0, irq_deliver});
      irq_nmi_req = 1'b1;
      cyc(2);
      chk("nmi passes", 32'h1, {31'h0, irq_deliver});
      irq_nmi_req = 1'b0;
      irq_return = 1'b1;
      @(negedge clk_sys);
      irq_return = 1'b0;
      cyc(1);
      chk("maskable passes", 32'h1, {31'h0, irq_deliver});
      irq_maskable_req = 1'b0;
   endtask

   task automatic t_setup();
      logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
      wr(1'b1, 32'hffff_ff07);
      chk("flushes", 32'h3, {30'h0, prog_cache_flush, data_cache_flush});
      l1d_req = 1'b1;
      xbar_req = 1'b1;
      cyc(1);
      chk("flush pulses end", 32'h0, {30'h0, prog_cache_flush, data_cache_flush});
      rd(1'b1, rd_val);
      chk("setup readback", 32'h8000_0007, rd_val);
      chk("crossbar wins", 32'h1, {30'h0, l1d_grant, xbar_grant});
      foreach (codes[i]) begin
         wr(1'b1, {29'h0, codes[i]});
         chk("way select", {29'h0, codes[i]}, {29'h0, level2_way_select});
         chk("no flush", 32'h0, {30'h0, prog_cache_flush, data_cache_flush});
      end
      wr(1'b1, 32'h0000_0004);
      cyc(1);
      chk("reserved way kept", 32'h7, {29'h0, level2_way_select});
      chk("data cache wins", 32'h2, {30'h0, l1d_grant, xbar_grant});
      l1d_req = 1'b0;
      xbar_req = 1'b0;
   endtask

   task automatic t_sleep();
      logic [5:0] deep [2] = '{6'h1a, 6'h1c};
      wr(1'b0, 32'h0000_2401);
      chk("light sleep enabled", 32'h2, {30'h0, sleep_light, sleep_deep});
      irq_maskable_req = 1'b1;
      cyc(1);
      chk("woken by enabled", 32'h0, {31'h0, sleep_light});
      irq_maskable_req = 1'b0;
      wr(1'b0, 32'h0000_4401);
      chk("light sleep any", 32'h1, {31'h0, sleep_light});
      irq_nmi_req = 1'b1;
      cyc(1);
      chk("woken by any", 32'h0, {31'h0, sleep_light});
      irq_nmi_req = 1'b0;
      foreach (deep[i]) begin
         wr(1'b0, {16'h0, deep[i], 10'h001});
         irq_maskable_req = 1'b1;
         irq_nmi_req = 1'b1;
         cyc(3);
         chk("deep sleep holds", 32'h1, {31'h0, sleep_deep});
         irq_maskable_req = 1'b0;
         irq_nmi_req = 1'b0;
         endian_strap_little = deep[i][1];
         do_reset();
         rd(1'b0, rd_val);
         chk("csr after wake", csr_exp(0, deep[i][1], 3'h0, 3'h0, 0, 0), rd_val);
         chk("deep left by reset", 32'h0, {31'h0, sleep_deep});
         chk("order output", {31'h0, deep[i][1]}, {31'h0, order_little});
      end
   endtask

   initial begin
      {rst_n, ctl_wr, ctl_rd, ctl_sel, clip_event, clip_cond_true} = 6'h00;
      {irq_taken, irq_return, irq_maskable_req, irq_nmi_req, l1d_req, xbar_req} = 6'h00;
      ctl_wdata = 32'h0000_0000;
      endian_strap_little = 1'b1;
      do_reset();
      t_reset();
      t_csr_fields();
      t_clip();
      t_irq();
      t_setup();
      t_sleep();
      report_and_stop();
   end

   // The whole sequence needs about 80 cycles; this limit of 5000 cycles leaves wide margin
   initial begin
      #250000;
      error_cnt++;
      report_and_stop();
   end
endmodule
